// [design/artx_cfg.svh]
// Constants for the accumulator register-transfer block.
// Assumes inclusion by the package and by the design modules.
`ifndef ARTX_CFG_SVH
`define ARTX_CFG_SVH
`define ARTX_NIB_W 4
`define ARTX_TMR_W 8
`define ARTX_ADC_W 10
`define ARTX_CTL_W 4
`define ARTX_MODE_BIT 3
`define ARTX_HI_MSB 7
`define ARTX_HI_LSB 4
`define ARTX_LO_MSB 3
`define ARTX_LO_LSB 0
`define ARTX_AD_HI_MSB 9
`define ARTX_AD_HI_LSB 6
`define ARTX_AD_LO_MSB 5
`define ARTX_AD_LO_LSB 2
`define ARTX_NIB_RST 4'h0
`define ARTX_OPC_W 3
`endif

// [design/artx_nibble_split.sv]
// Splits an 8-bit value into high and low nibbles for B and A.
// Assumes purely combinational use inside the transfer block.
`timescale 1ns/10ps
`include "artx_cfg.svh"
module artx_nibble_split (
  input wire logic [`ARTX_TMR_W-1:0] i_value,
  output artx_pkg::artx_pair_s o_pair
);
  import artx_pkg::*;
  assign o_pair.b = i_value[`ARTX_HI_MSB:`ARTX_HI_LSB];
  assign o_pair.a = i_value[`ARTX_LO_MSB:`ARTX_LO_LSB];
endmodule // artx_nibble_split

// [design/artx_pkg.sv]
// Types shared by the accumulator register-transfer block.
// Assumes artx_cfg.svh is on the include path.
`include "artx_cfg.svh"
package artx_pkg;
  typedef enum logic [`ARTX_OPC_W-1:0] {
    ARTX_OP_NONE,
    ARTX_OP_COPY_B_TO_A,
    ARTX_OP_READ_TIMER_ONE,
    ARTX_OP_READ_TIMER_TWO,
    ARTX_OP_READ_CONVERTER_RESULT
  } artx_op_e;

  typedef struct packed {
    logic [`ARTX_NIB_W-1:0] b;
    logic [`ARTX_NIB_W-1:0] a;
  } artx_pair_s;

  typedef struct packed {
    logic [`ARTX_TMR_W-1:0] timer_one;
    logic [`ARTX_TMR_W-1:0] timer_two;
    logic [`ARTX_ADC_W-1:0] converter_result;
    logic [`ARTX_TMR_W-1:0] comparator_reg;
    logic [`ARTX_CTL_W-1:0] converter_control_reg;
  } artx_src_s;
endpackage

// [design/artx_register_transfer.sv]
// Executes four register-transfer instructions that load accumulator A and register B.
// Holds the A and B registers, the op decode and the completion pulse.
// Assumes the decoder presents one op per executing instruction cycle, same clock.
// Assumes timer counts, converter result and control register are flop outputs on that clock.
//
// Contract
// - Copy-B-to-A loads A from B in one word, one cycle.
// - Read-timer-one puts timer 1 bits 7..4 into B.
// - Read-timer-one puts timer 1 bits 3..0 into A.
// - Read-timer-two puts timer 2 bits 7..4 into B.
// - Read-timer-two puts timer 2 bits 3..0 into A.
// - Converter read, mode clear: B gets result 9..6, A gets 5..2.
// - Converter read, mode set: B gets comparator 7..4, A gets 3..0.
// - Mode comes from control bit 3, sampled at execution.
`timescale 1ns/10ps
`include "artx_cfg.svh"
module artx_register_transfer (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire artx_pkg::artx_op_e i_op,
  input wire artx_pkg::artx_src_s i_src,
  input wire logic i_load_a,
  input wire logic i_load_b,
  input wire logic [`ARTX_NIB_W-1:0] i_load_value,
  output artx_pkg::artx_pair_s o_regs,
  output logic o_carry_write,
  output logic o_skip_next,
  output logic o_done
);
  import artx_pkg::*;

  // ----------------------------------------------------------------
  // Source splitting
  // ----------------------------------------------------------------
  // Timers, comparator and converter result all split the same way, so one small
  // module serves every source and the nibble order cannot drift between them.
  artx_pair_s t1_pair;
  artx_pair_s t2_pair;
  artx_pair_s cmp_pair;
  artx_pair_s adc_pair;
  logic compare_mode_select_bit;

  artx_nibble_split u_t1 (
    .i_value(i_src.timer_one),
    .o_pair(t1_pair)
  );
  artx_nibble_split u_t2 (
    .i_value(i_src.timer_two),
    .o_pair(t2_pair)
  );
  artx_nibble_split u_cmp (
    .i_value(i_src.comparator_reg),
    .o_pair(cmp_pair)
  );

  // The two low result bits are dropped; the converter read only yields eight of ten bits.
  artx_nibble_split u_adc (
    .i_value(i_src.converter_result[`ARTX_AD_HI_MSB:`ARTX_AD_LO_LSB]),
    .o_pair(adc_pair)
  );
  assign compare_mode_select_bit = i_src.converter_control_reg[`ARTX_MODE_BIT];

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // A transfer op owns both registers for its cycle, so load strobes from other
  // instructions are dropped rather than merged with it.
  logic op_idle;
  logic op_copy;
  logic op_timer_one;
  logic op_timer_two;
  logic op_converter;
  logic op_transfer;
  logic load_a_ok;
  logic load_b_ok;

  always_comb begin
    unique case (i_op)
      ARTX_OP_NONE: begin
        op_idle = 1'b1;
        op_copy = 1'b0;
        op_timer_one = 1'b0;
        op_timer_two = 1'b0;
        op_converter = 1'b0;
      end
      ARTX_OP_COPY_B_TO_A: begin
        op_idle = 1'b0;
        op_copy = 1'b1;
        op_timer_one = 1'b0;
        op_timer_two = 1'b0;
        op_converter = 1'b0;
      end
      ARTX_OP_READ_TIMER_ONE: begin
        op_idle = 1'b0;
        op_copy = 1'b0;
        op_timer_one = 1'b1;
        op_timer_two = 1'b0;
        op_converter = 1'b0;
      end
      ARTX_OP_READ_TIMER_TWO: begin
        op_idle = 1'b0;
        op_copy = 1'b0;
        op_timer_one = 1'b0;
        op_timer_two = 1'b1;
        op_converter = 1'b0;
      end
      ARTX_OP_READ_CONVERTER_RESULT: begin
        op_idle = 1'b0;
        op_copy = 1'b0;
        op_timer_one = 1'b0;
        op_timer_two = 1'b0;
        op_converter = 1'b1;
      end
      default: begin
        // Unused codes act as a no-op: no load is honoured and no done pulse follows.
        op_idle = 1'b0;
        op_copy = 1'b0;
        op_timer_one = 1'b0;
        op_timer_two = 1'b0;
        op_converter = 1'b0;
      end
    endcase
    op_transfer = op_copy | op_timer_one | op_timer_two | op_converter;
    load_a_ok = i_load_a & op_idle;
    load_b_ok = i_load_b & op_idle;
  end

  // ----------------------------------------------------------------
  // Accumulator and B register
  // ----------------------------------------------------------------
  artx_pair_s regs_q;
  artx_pair_s regs_d;

  always_comb begin
    regs_d = regs_q;
    if (op_copy) begin
      regs_d.a = regs_q.b;
    end else if (op_timer_one) begin
      regs_d.b = t1_pair.b;
      regs_d.a = t1_pair.a;
    end else if (op_timer_two) begin
      regs_d.b = t2_pair.b;
      regs_d.a = t2_pair.a;
    end else if (op_converter) begin
      // Mode is looked at only in the executing cycle, never latched earlier.
      if (compare_mode_select_bit) begin
        regs_d = cmp_pair;
      end else begin
        regs_d = adc_pair;
      end
    end else begin
      if (load_a_ok) begin
        regs_d.a = i_load_value;
      end
      if (load_b_ok) begin
        regs_d.b = i_load_value;
      end
    end
  end

  // Reset clears both registers so a copy straight after reset moves a known value.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      regs_q.a <= `ARTX_NIB_RST;
      regs_q.b <= `ARTX_NIB_RST;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ----------------------------------------------------------------
  // Completion pulse
  // ----------------------------------------------------------------
  logic done_q;
  logic done_d;

  always_comb begin
    done_d = op_transfer;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Side effects
  // ----------------------------------------------------------------
  // Carry and skip belong to other instructions; these ops hold both low so a merged
  // flag path elsewhere never sees a request from a transfer. Sources are only read.
  logic carry_q;
  logic carry_d;
  logic skip_q;
  logic skip_d;

  always_comb begin
    carry_d = 1'b0;
    skip_d = 1'b0;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      carry_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
      skip_q <= skip_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop, so nothing combinational reaches the CPU datapath.
  assign o_regs = regs_q;
  assign o_done = done_q;
  assign o_carry_write = carry_q;
  assign o_skip_next = skip_q;
endmodule // artx_register_transfer

// [tb/artx_chk_sva.sv]
// Port checker for the transfer block.
// Bound by name to artx_register_transfer.
`timescale 1ns/10ps
module artx_chk (
  input logic i_clock,
  input logic i_reset,
  input artx_pkg::artx_op_e i_op,
  input artx_pkg::artx_src_s i_src,
  input artx_pkg::artx_pair_s o_regs,
  input logic o_carry_write,
  input logic o_skip_next,
  input logic o_done
);
  import artx_pkg::*;
  // --
  // Results land one edge after the op.
  // --
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire d=i_op==ARTX_OP_READ_CONVERTER_RESULT;
  wire m=i_src.converter_control_reg[3];
  property p_cp; i_op==ARTX_OP_COPY_B_TO_A |=> o_regs=={2{$past(o_regs.b)}}; endproperty
  a_cp: assert property (p_cp) else $error("cp");
  property p_t1; i_op==ARTX_OP_READ_TIMER_ONE |=> o_regs==$past(i_src.timer_one); endproperty
  a_t1: assert property (p_t1) else $error("t1");
  property p_t2; i_op==ARTX_OP_READ_TIMER_TWO |=> o_regs==$past(i_src.timer_two); endproperty
  a_t2: assert property (p_t2) else $error("t2");
  property p_ad; d && !m |=> o_regs==$past(i_src.converter_result[9:2]); endproperty
  a_ad: assert property (p_ad) else $error("ad");
  property p_cm; d && m |=> o_regs==$past(i_src.comparator_reg); endproperty
  a_cm: assert property (p_cm) else $error("cm");
  property p_dn; i_op!=ARTX_OP_NONE && i_op<=ARTX_OP_READ_CONVERTER_RESULT |=> o_done; endproperty
  a_dn: assert property (p_dn) else $error("done missing");
  property p_nd; i_op==ARTX_OP_NONE |=> !o_done; endproperty
  a_nd: assert property (p_nd) else $error("spurious done");
  property p_sd; !o_carry_write && !o_skip_next; endproperty
  a_sd: assert property (p_sd) else $error("carry or skip driven");
endmodule // artx_chk
bind artx_register_transfer artx_chk i_chk (
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_op(i_op),
  .i_src(i_src),
  .o_regs(o_regs),
  .o_carry_write(o_carry_write),
  .o_skip_next(o_skip_next),
  .o_done(o_done)
);

// [tb/testbench.sv]
// Random bench with an int model of B and A.
// Assumes the design files compile first.
`timescale 1ns/10ps
`define CK(g,e) begin tests_run++; if ((g)!==(e)) begin errors++; $display("[FAIL] %0t got %0h expected %0h",$time,(g),(e)); end end
module testbench;
  import artx_pkg::*;
  logic i_clock=0, i_reset=1, i_load_a=0, i_load_b=0, o_carry_write, o_skip_next, o_done;
  logic [3:0] i_load_value=0;
  artx_op_e i_op=ARTX_OP_NONE;
  artx_src_s i_src='0;
  artx_pair_s o_regs;
  int errors=0, tests_run=0, seed=16440, v=0;
  always #5 i_clock=~i_clock;
  artx_register_transfer i_artx_register_transfer (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_op(i_op),
    .i_src(i_src),
    .i_load_a(i_load_a),
    .i_load_b(i_load_b),
    .i_load_value(i_load_value),
    .o_regs(o_regs),
    .o_carry_write(o_carry_write),
    .o_skip_next(o_skip_next),
    .o_done(o_done)
  );
  // --
  // Verdict and hang guard.
  // --
  task summarize;
    $display("errors=%0d tests_run=%0d",errors,tests_run);
    if (errors==0 && tests_run>0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #90000;
    errors++;
    summarize;
  end
  // Loads are randomised alongside ops, so refused loads are hit often.
  initial begin
    repeat (5) @(posedge i_clock);
    #1;
    `CK(o_regs,8'h00)
    `CK({o_carry_write,o_skip_next,o_done},3'h0)
    // A reset every thousand cycles checks that A and B clear again in mid-run.
    for (int n=0; n<4000; n++) begin
      i_reset=(n%1000==999);
      i_op=artx_op_e'($unsigned($random(seed))%5);
      {i_src,i_load_value,i_load_a,i_load_b}=44'({$random(seed),$random(seed)});
      case (i_op)
        ARTX_OP_COPY_B_TO_A: v=v/16*17;
        ARTX_OP_READ_TIMER_ONE: v=i_src.timer_one;
        ARTX_OP_READ_TIMER_TWO: v=i_src.timer_two;
        ARTX_OP_READ_CONVERTER_RESULT: v=i_src.converter_control_reg[3]?
          i_src.comparator_reg:i_src.converter_result/4;
        default: v=(i_load_b?i_load_value:v/16)*16+(i_load_a?i_load_value:v%16);
      endcase
      if (i_reset) v=0;
      @(posedge i_clock);
      #1;
      `CK(o_regs,8'(v))
      `CK(o_done,!i_reset && i_op!=ARTX_OP_NONE)
      `CK({o_carry_write,o_skip_next},2'h0)
    end
    summarize;
  end
endmodule // testbench
